/* pkg/bsr_pkg.sv */
// Purpose: constants for the bank-one special register map
// Assumes: 8-bit data memory, 8-bit register address (bank bit + 7)
// Notes: offsets are byte addresses in the 00h-FFh data space
// What this block does
// - unmapped locations and bits read zero, ignore writes
// - shared registers decode same from both banks
// - program counter high part not a register
// - latch five bits, copied on low byte write
// - pin and watchdog resets use other-reset column
// - unchanged bits keep value on pin and watchdog reset
// - serial status top two bits read zero
package bsr_pkg;
   localparam logic [7:0] A_INDIRECT  = 8'h80;
   localparam logic [7:0] A_OPTION    = 8'h81;
   localparam logic [7:0] A_PCL       = 8'h82;
   localparam logic [7:0] A_STATUS    = 8'h83;
   localparam logic [7:0] A_POINTER   = 8'h84;
   localparam logic [7:0] A_TRIS_A    = 8'h85;
   localparam logic [7:0] A_TRIS_B    = 8'h86;
   localparam logic [7:0] A_TRIS_C    = 8'h87;
   localparam logic [7:0] A_PROGRAM_COUNTER_HIGH_LATCH    = 8'h8A;
   localparam logic [7:0] A_INTCTL    = 8'h8B;
   localparam logic [7:0] A_PIE       = 8'h8C;
   localparam logic [7:0] A_PWRCAUSE  = 8'h8E;
   localparam logic [7:0] A_T2PER     = 8'h92;
   localparam logic [7:0] A_SLVADDR   = 8'h93;
   localparam logic [7:0] A_SERSTAT   = 8'h94;
   localparam logic [7:0] A_ANACFG    = 8'h9F;
   localparam logic [7:0] BANK_BIT    = 8'h80;
   localparam logic [7:0] ZERO8       = 8'h00;
   localparam logic [7:0] ONES8       = 8'hFF;
   // implemented-bit masks
   localparam logic [7:0] M_TRIS_A    = 8'h3F;
   localparam logic [7:0] M_PROGRAM_COUNTER_HIGH_LATCH    = 8'h1F;
   localparam logic [7:0] M_PIE       = 8'h4F;
   localparam logic [7:0] M_PWRCAUSE  = 8'h03;
   localparam logic [7:0] M_SERSTAT   = 8'h3F;
   localparam logic [7:0] M_ANACFG    = 8'h07;
   // status: bits 7:5 and 2:0 writable, 4:3 timeout/powerdown read-only
   localparam logic [7:0] M_STAT_WR   = 8'hE7;
   localparam logic [7:0] M_STAT_FLAG = 8'h18;
   localparam logic [7:0] STAT_POR    = 8'h18;
   localparam logic [7:0] M_STAT_KEEP = 8'h07;
   localparam logic [7:0] M_INT_KEEP  = 8'h01;
   localparam logic [7:0] PWR_POR     = 8'h00;
   // reset causes
   typedef enum logic [1:0]
   {
      BSR_RST_POWER = 2'h0,
      BSR_RST_BROWN = 2'h1,
      BSR_RST_PIN   = 2'h3,
      BSR_RST_WDOG  = 2'h2
   } bsr_cause_t;
endpackage

/* verilog/bsr_ram.sv */
`timescale 1ns/1ps
// Purpose: general-purpose data byte storage behind the indirect window
// Assumes: flip-flop storage, index addressed, same clock as the bank
// Notes: contents are unknown-free zero after every reset, whatever the cause
module bsr_ram
   import bsr_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       nrst,
   // access port
   input  wire logic       we,
   input  wire logic [6:0] idx,
   input  wire logic [7:0] wdata,
   output      logic [7:0] rdata
);
   logic [7:0] mem_q [128];

   // plain byte store; read is combinational, the caller registers it
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < 128; i++)
            mem_q[i] <= ZERO8;
      end
      else if (we)
         mem_q[idx] <= wdata;
   end

   assign rdata = mem_q[idx];
endmodule

/* verilog/bsr_bank.sv */
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
// Purpose: bank-one special register file with indirect window
// Assumes: reg_addr bit 7 is the bank bit; status/pointer etc shared
// Notes: power-up vs other resets chosen by rst_cause at reset release
module bsr_bank
   import bsr_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       nrst,
   // reset cause, sampled on the first edge after release
   input  wire logic [1:0] rst_cause,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output      logic [7:0] reg_rdata,
   // core side
   input  wire logic       core_flag_we,
   input  wire logic [2:0] core_flags,
   input  wire logic       core_timeout_n,
   input  wire logic       core_powerdown_n,
   output      logic [12:0] program_counter,
   // control outputs to peripherals
   output      logic [7:0] option_cfg,
   output      logic [5:0] port_a_dir,
   output      logic [7:0] port_b_dir,
   output      logic [7:0] port_c_dir,
   output      logic [7:0] int_ctl,
   output      logic [7:0] periph_irq_en,
   output      logic [7:0] timer2_period,
   output      logic [7:0] serial_addr,
   output      logic [2:0] analog_cfg,
   // serial status bits set by the serial unit
   input  wire logic       ser_stat_we,
   input  wire logic [5:0] ser_stat_in
);
   logic [7:0]  option_q, pcl_q, status_q, ptr_q, port_a_direction_q, port_b_direction_q;
   logic [7:0]  port_c_direction_q, program_counter_high_latch_q, intc_q, pie_q, pwr_q, pr2_q;
   logic [7:0]  sadd_q, sstat_q, acfg_q, rdata_q;
   logic [4:0]  pc_hi_q;
   logic        init_q;
   logic [7:0]  dec_addr, ram_rdata, rd_d;
   logic        cold;
   logic        ram_we;

   // fold both banks onto one decode; unmapped bank-0 rows miss below
   function automatic logic [7:0] fold(input logic [7:0] a);
      fold = a | BANK_BIT;
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = (fold(a) == r);
   endfunction

   assign dec_addr = reg_addr;
   assign cold     = (rst_cause == BSR_RST_POWER)
                   || (rst_cause == BSR_RST_BROWN);

   // indirect window: pointer low 7 bits index the byte store
   // pointer values inside the register area still land in the store;
   // a real core would route them back to the map, kept simple here
   assign ram_we = reg_wr && hit(dec_addr, A_INDIRECT);

   bsr_ram u_ram
   (
      .mclk  (mclk),
      .nrst  (nrst),
      .we    (ram_we),
      .idx   (ptr_q[6:0]),
      .wdata (reg_wdata),
      .rdata (ram_rdata)
   );

   // first edge after release applies the cause-dependent values
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         init_q <= 1'b1;
      else
         init_q <= 1'b0;
   end

   // status: bank bits writable, flags from core, to/pd read-only;
   // no async reset, else a warm reset would lose the kept flags.
   // init_q stays high all through reset and applies the cause values
   always_ff @(posedge mclk)
   begin
      if (init_q)
      begin
         if (cold)
            status_q <= STAT_POR;
         else
            status_q <= (status_q & M_STAT_KEEP) | M_STAT_FLAG;
      end
      else
      begin
         if (reg_wr && hit(dec_addr, A_STATUS))
            status_q <= (reg_wdata & M_STAT_WR)
                      | (status_q & M_STAT_FLAG);
         if (core_flag_we)
            status_q[2:0] <= core_flags;
         status_q[4] <= core_timeout_n;
         status_q[3] <= core_powerdown_n;
      end
   end

   // pointer: unknown on power-up (cleared here, also on brown-out), kept on pin and watchdog resets
   always_ff @(posedge mclk)
   begin
      if (init_q)
      begin
         if (cold)
            ptr_q <= ZERO8;
      end
      else if (reg_wr && hit(dec_addr, A_POINTER))
         ptr_q <= reg_wdata;
   end

   // program counter: high part only moves on a low-byte write
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         pcl_q    <= ZERO8;
         program_counter_high_latch_q <= ZERO8;
         pc_hi_q  <= 5'h00;
      end
      else if (init_q)
      begin
         pcl_q    <= ZERO8;
         program_counter_high_latch_q <= ZERO8;
         pc_hi_q  <= 5'h00;
      end
      else
      begin
         if (reg_wr && hit(dec_addr, A_PROGRAM_COUNTER_HIGH_LATCH))
            program_counter_high_latch_q <= reg_wdata & M_PROGRAM_COUNTER_HIGH_LATCH;
         if (reg_wr && hit(dec_addr, A_PCL))
         begin
            pcl_q   <= reg_wdata;
            pc_hi_q <= program_counter_high_latch_q[4:0];
         end
      end
   end

   // upper counter bits have no address of their own
   assign program_counter = {pc_hi_q, pcl_q};

   // interrupt control: flag bit 0 kept over pin and watchdog resets
   always_ff @(posedge mclk)
   begin
      if (init_q)
         intc_q <= cold ? ZERO8 : (intc_q & M_INT_KEEP);
      else if (reg_wr && hit(dec_addr, A_INTCTL))
         intc_q <= reg_wdata;
   end

   // power cause: both flags low after power-up or brown-out, kept on pin and watchdog resets
   always_ff @(posedge mclk)
   begin
      if (init_q)
      begin
         if (cold)
            pwr_q <= PWR_POR;
      end
      else if (reg_wr && (reg_addr == A_PWRCAUSE))
         pwr_q <= reg_wdata & M_PWRCAUSE;
   end

   // plain bank-one registers with the same value on every reset
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         option_q <= ONES8;
         port_a_direction_q  <= M_TRIS_A;
         port_b_direction_q  <= ONES8;
         port_c_direction_q  <= ONES8;
         pie_q    <= ZERO8;
         pr2_q    <= ONES8;
         sadd_q   <= ZERO8;
         acfg_q   <= ZERO8;
      end
      else if (init_q)
      begin
         option_q <= ONES8;
         port_a_direction_q  <= M_TRIS_A;
         port_b_direction_q  <= ONES8;
         port_c_direction_q  <= ONES8;
         pie_q    <= ZERO8;
         pr2_q    <= ONES8;
         sadd_q   <= ZERO8;
         acfg_q   <= ZERO8;
      end
      else if (reg_wr && !reg_addr[7])
      begin
         // bank-zero rows of these addresses belong elsewhere
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            A_OPTION:  option_q <= reg_wdata;
            A_TRIS_A:  port_a_direction_q  <= reg_wdata & M_TRIS_A;
            A_TRIS_B:  port_b_direction_q  <= reg_wdata;
            A_TRIS_C:  port_c_direction_q  <= reg_wdata;
            A_PIE:     pie_q    <= reg_wdata & M_PIE;
            A_T2PER:   pr2_q    <= reg_wdata;
            A_SLVADDR: sadd_q   <= reg_wdata;
            A_ANACFG:  acfg_q   <= reg_wdata & M_ANACFG;
            default:   ;
         endcase
      end
   end

   // serial status: top two bits never stored
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         sstat_q <= ZERO8;
      else if (init_q)
         sstat_q <= ZERO8;
      else if (ser_stat_we)
         sstat_q <= {2'b00, ser_stat_in};
      else if (reg_wr && (reg_addr == A_SERSTAT))
         sstat_q <= reg_wdata & M_SERSTAT;
   end

   // read mux; every unlisted location answers zero
   always_comb
   begin
      rd_d = ZERO8;
      if (hit(dec_addr, A_INDIRECT))
         rd_d = ram_rdata;
      else if (hit(dec_addr, A_PCL))
         rd_d = pcl_q;
      else if (hit(dec_addr, A_STATUS))
         rd_d = status_q;
      else if (hit(dec_addr, A_POINTER))
         rd_d = ptr_q;
      else if (hit(dec_addr, A_PROGRAM_COUNTER_HIGH_LATCH))
         rd_d = program_counter_high_latch_q;
      else if (hit(dec_addr, A_INTCTL))
         rd_d = intc_q;
      else if (reg_addr[7])
      begin
         case (reg_addr)
            A_OPTION:   rd_d = option_q;
            A_TRIS_A:   rd_d = port_a_direction_q;
            A_TRIS_B:   rd_d = port_b_direction_q;
            A_TRIS_C:   rd_d = port_c_direction_q;
            A_PIE:      rd_d = pie_q;
            A_PWRCAUSE: rd_d = pwr_q;
            A_T2PER:    rd_d = pr2_q;
            A_SLVADDR:  rd_d = sadd_q;
            A_SERSTAT:  rd_d = sstat_q & M_SERSTAT;
            A_ANACFG:   rd_d = acfg_q;
            default:    rd_d = ZERO8;
         endcase
      end
   end

   // read data held for exactly the cycle after the strobe
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         rdata_q <= ZERO8;
      else if (reg_rd)
         rdata_q <= rd_d;
      else
         rdata_q <= ZERO8;
   end

   assign reg_rdata     = rdata_q;
   assign option_cfg    = option_q;
   assign port_a_dir    = port_a_direction_q[5:0];
   assign port_b_dir    = port_b_direction_q;
   assign port_c_dir    = port_c_direction_q;
   assign int_ctl       = intc_q;
   assign periph_irq_en = pie_q;
   assign timer2_period = pr2_q;
   assign serial_addr   = sadd_q;
   assign analog_cfg    = acfg_q[2:0];

   // assertions
   property p_unmapped_zero;
      @(posedge mclk) disable iff (!nrst)
      (reg_rd && (reg_addr == 8'h88 || reg_addr == 8'h9A))
         |=> (reg_rdata == ZERO8);
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero)
      else $error("unmapped read not zero");

   property p_shared_ptr;
      @(posedge mclk) disable iff (!nrst)
      (reg_wr && reg_addr == (A_POINTER & ~BANK_BIT)) ##1
      (reg_rd && reg_addr == A_POINTER)
         |=> (reg_rdata == $past(reg_wdata, 2));
   endproperty
   a_shared_ptr: assert property (p_shared_ptr)
      else $error("bank zero pointer write not seen in bank one");

   property p_pc_hi_hold;
      @(posedge mclk) disable iff (!nrst || init_q)
      (reg_wr && hit(reg_addr, A_PROGRAM_COUNTER_HIGH_LATCH) && !hit(reg_addr, A_PCL))
         |=> (program_counter[12:8] == $past(pc_hi_q));
   endproperty
   a_pc_hi_hold: assert property (p_pc_hi_hold)
      else $error("counter high moved on latch write");

   property p_pc_hi_load;
      @(posedge mclk) disable iff (!nrst || init_q)
      (reg_wr && hit(reg_addr, A_PCL))
         |=> (program_counter[12:8] == $past(program_counter_high_latch_q[4:0]));
   endproperty
   a_pc_hi_load: assert property (p_pc_hi_load)
      else $error("latch not copied on low byte write");

   property p_ser_top_zero;
      @(posedge mclk) disable iff (!nrst)
      (reg_rd && reg_addr == A_SERSTAT) |=> (reg_rdata[7:6] == 2'b00);
   endproperty
   a_ser_top_zero: assert property (p_ser_top_zero)
      else $error("serial status top bits not zero");

   property p_warm_keep;
      @(posedge mclk) disable iff (!nrst)
      (init_q && !cold) |=> (pwr_q == $past(pwr_q));
   endproperty
   a_warm_keep: assert property (p_warm_keep)
      else $error("power cause changed on warm reset");

   property p_cold_status;
      @(posedge mclk) disable iff (!nrst)
      (init_q && cold) |=> (status_q[7:5] == 3'b000 && pwr_q == PWR_POR);
   endproperty
   a_cold_status: assert property (p_cold_status)
      else $error("power reset values not applied");

   property p_indirect;
      @(posedge mclk) disable iff (!nrst)
      (reg_wr && hit(reg_addr, A_INDIRECT)) ##1
      (reg_rd && hit(reg_addr, A_INDIRECT) && $stable(ptr_q))
         |=> (reg_rdata == $past(reg_wdata, 2));
   endproperty
   a_indirect: assert property (p_indirect)
      else $error("indirect window lost the byte");
endmodule

/* verification/bsr_core_model.sv */
`timescale 1ns/1ps
// Purpose: processor-core model that reads and writes the register port
// Assumes: strobes launched right after a rising edge, one cycle long
// Notes: idle lines carry the inverse of the last value, never stale data
module bsr_core_model
   import bsr_pkg::*;
(
   // clock
   input  wire logic       mclk,
   // register port
   output      logic [7:0] reg_addr,
   output      logic [7:0] reg_wdata,
   output      logic       reg_wr,
   output      logic       reg_rd,
   input  wire logic [7:0] reg_rdata
);
   // quiet bus at time zero
   initial
   begin
      reg_addr  = ZERO8;
      reg_wdata = ZERO8;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   // one-cycle write; reserved bank bits always sent clear
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a[6:0] == A_STATUS[6:0])
         v = d & 8'h3F;
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~v;
   endtask

   // write then read with no idle cycle between the two strobes
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                        input logic [7:0] ra, output logic [7:0] q);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b1;
      reg_addr  <= ra;
      reg_wdata <= ~d;
      @(posedge mclk);
      reg_rd    <= 1'b0;
      reg_addr  <= ~ra;
      @(negedge mclk);
      q = reg_rdata;
   endtask

   // one-cycle read; data taken mid-cycle, the only cycle it stands
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      @(negedge mclk);
      d = reg_rdata;
   endtask
endmodule

/* verification/tb_bsr_bank.sv */
`timescale 1ns/1ps
// Purpose: self-checking bench for the bank-one register file
// Assumes: core model issues every register access
// Notes: status low flags are masked after the brown-out reset, checked exactly after power-up
module tb_bsr_bank
   import bsr_pkg::*;
;
   logic        mclk = 1'b0;
   logic        nrst = 1'b0;
   logic [1:0]  rst_cause = BSR_RST_POWER;
   logic        core_flag_we = 1'b0;
   logic [2:0]  core_flags = 3'h0;
   logic        core_timeout_n = 1'b1;
   logic        core_powerdown_n = 1'b1;
   logic        ser_stat_we = 1'b0;
   logic [5:0]  ser_stat_in = 6'h00;
   wire  [7:0]  reg_addr, reg_wdata, reg_rdata, option_cfg;
   wire         reg_wr, reg_rd;
   wire  [12:0] program_counter;
   wire  [5:0]  port_a_dir;
   wire  [7:0]  port_b_dir, port_c_dir, int_ctl, periph_irq_en;
   wire  [7:0]  timer2_period, serial_addr;
   wire  [2:0]  analog_cfg;
   int          n_errors = 0;
   int          check_count = 0;

   // 250 MHz clock
   always #2 mclk = ~mclk;

   bsr_core_model i_core (.mclk(mclk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));

   bsr_bank i_dut (.mclk(mclk), .nrst(nrst), .rst_cause(rst_cause),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .core_flag_we(core_flag_we), .core_flags(core_flags),
      .core_timeout_n(core_timeout_n),
      .core_powerdown_n(core_powerdown_n),
      .program_counter(program_counter), .option_cfg(option_cfg),
      .port_a_dir(port_a_dir), .port_b_dir(port_b_dir),
      .port_c_dir(port_c_dir), .int_ctl(int_ctl),
      .periph_irq_en(periph_irq_en), .timer2_period(timer2_period),
      .serial_addr(serial_addr), .analog_cfg(analog_cfg),
      .ser_stat_we(ser_stat_we), .ser_stat_in(ser_stat_in));

   task automatic chk(string n, logic [12:0] e, logic [12:0] s);
      check_count++;
      if (s !== e)
      begin
         $display("MISMATCH %s expected %h seen %h", n, e, s);
         n_errors++;
      end
   endtask

   task automatic rchk(logic [7:0] a, logic [7:0] e);
      logic [7:0] v;
      i_core.rd(a, v);
      chk($sformatf("reg %h", a), {5'h00, e}, {5'h00, v});
   endtask

   // reset held 12 cycles; first access launched on the third edge after release
   task automatic do_reset(logic [1:0] c);
      @(posedge mclk);
      nrst      <= 1'b0;
      rst_cause <= c;
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      repeat (2) @(posedge mclk);
   endtask

   task automatic t_reset();
      logic [7:0] ra [0:13];
      logic [7:0] re [0:13];
      ra = '{8'h81, 8'h82, 8'h83, 8'h85, 8'h86, 8'h87, 8'h8A, 8'h8C,
             8'h8E, 8'h92, 8'h93, 8'h94, 8'h9F, 8'h88};
      re = '{8'hFF, 8'h00, 8'h18, 8'h3F, 8'hFF, 8'hFF, 8'h00, 8'h00,
             8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 14; i++)
         rchk(ra[i], re[i]);
      chk("option_cfg", {5'h00, ONES8}, {5'h00, option_cfg});
      chk("port_b_dir", 13'h00FF, {5'h00, port_b_dir});
      chk("port_c_dir", 13'h00FF, {5'h00, port_c_dir});
      chk("int_ctl", 13'h0000, {5'h00, int_ctl});
      chk("periph_irq_en", 13'h0000, {5'h00, periph_irq_en});
      chk("timer2_period", 13'h00FF, {5'h00, timer2_period});
      chk("serial_addr", 13'h0000, {5'h00, serial_addr});
      chk("analog_cfg", 13'h0000, {10'h000, analog_cfg});
      $display("test reset values done");
   endtask

   task automatic t_unimpl();
      logic [7:0] ra [0:9];
      logic [7:0] re [0:9];
      ra = '{8'h85, 8'h8A, 8'h8C, 8'h8E, 8'h94, 8'h9F, 8'h88, 8'h8D,
             8'h9E, 8'h01};
      re = '{8'h3F, 8'h1F, 8'h4F, 8'h03, 8'h3F, 8'h07, 8'h00, 8'h00,
             8'h00, 8'h00};
      for (int i = 0; i < 10; i++)
      begin
         i_core.wr(ra[i], ONES8);
         rchk(ra[i], re[i]);
      end
      chk("port_a_dir", 13'h003F, {7'h00, port_a_dir});
      chk("periph_irq_en", 13'h004F, {5'h00, periph_irq_en});
      chk("analog_cfg", 13'h0007, {10'h000, analog_cfg});
      i_core.wr(8'h93, 8'hC3);
      i_core.wr(8'h92, 8'h3C);
      @(negedge mclk);
      chk("serial_addr", 13'h00C3, {5'h00, serial_addr});
      chk("timer2_period", 13'h003C, {5'h00, timer2_period});
      $display("test unimplemented bits done");
   endtask

   task automatic t_shared();
      logic [7:0] v;
      i_core.wr(8'h04, 8'h5A);
      rchk(8'h84, 8'h5A);
      i_core.wr(8'h0A, 8'h15);
      rchk(8'h8A, 8'h15);
      i_core.wr(8'h83, 8'h20);
      rchk(8'h03, 8'h38);
      i_core.wr_rd(8'h04, 8'h66, 8'h84, v);
      chk("pointer back to back", 13'h0066, {5'h00, v});
      i_core.wr(8'h0E, 8'h00);
      rchk(8'h8E, 8'h03);
      $display("test shared decode done");
   endtask

   task automatic t_pc();
      i_core.wr(8'h8A, 8'h15);
      @(negedge mclk);
      chk("pc", 13'h0000, program_counter);
      i_core.wr(8'h82, 8'h34);
      @(negedge mclk);
      chk("pc", 13'h1534, program_counter);
      rchk(8'h82, 8'h34);
      $display("test program counter done");
   endtask

   task automatic t_indirect();
      logic [7:0] v;
      i_core.wr(8'h84, 8'h10);
      i_core.wr(8'h80, 8'hA5);
      i_core.wr(8'h84, 8'h11);
      i_core.wr(8'h80, 8'h3C);
      i_core.wr(8'h84, 8'h10);
      rchk(8'h80, 8'hA5);
      rchk(8'h84, 8'h10);
      i_core.wr(8'h84, 8'h11);
      rchk(8'h00, 8'h3C);
      i_core.wr_rd(8'h80, 8'h77, 8'h80, v);
      chk("indirect back to back", 13'h0077, {5'h00, v});
      $display("test indirect window done");
   endtask

   task automatic t_core();
      i_core.wr(8'h83, 8'h00);
      @(posedge mclk);
      core_flags     <= 3'h5;
      core_flag_we   <= 1'b1;
      core_timeout_n <= 1'b0;
      ser_stat_we    <= 1'b1;
      ser_stat_in    <= 6'h2A;
      @(posedge mclk);
      core_flag_we <= 1'b0;
      ser_stat_we  <= 1'b0;
      rchk(8'h83, 8'h0D);
      rchk(8'h94, 8'h2A);
      @(posedge mclk);
      core_timeout_n <= 1'b1;
      $display("test core inputs done");
   endtask

   // warm resets keep flags, cold ones clear them
   task automatic t_warm(logic [1:0] c, bit cold);
      logic [7:0] v;
      i_core.wr(8'h81, 8'h00);
      i_core.wr(8'h83, 8'h27);
      i_core.wr(8'h8B, 8'h81);
      i_core.wr(8'h84, 8'h3C);
      i_core.wr(8'h8E, 8'h03);
      do_reset(c);
      rchk(8'h81, 8'hFF);
      i_core.rd(8'h83, v);
      if (cold)
         chk("status", 13'h0018, {5'h00, v & 8'hF8});
      else
         chk("status", 13'h001F, {5'h00, v});
      i_core.rd(8'h8B, v);
      if (!cold)
         chk("int_ctl", 13'h0001, {5'h00, v});
      else
         chk("int_ctl", 13'h0000, {5'h00, v & 8'hFE});
      i_core.rd(8'h8E, v);
      if (cold)
         chk("power_cause", 13'h0000, {5'h00, v});
      else
         chk("power_cause", 13'h0003, {5'h00, v});
      i_core.rd(8'h84, v);
      if (!cold)
         chk("pointer", 13'h003C, {5'h00, v});
      $display("test reset cause %0d done", c);
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // hang guard
   initial
   begin
      #200000;
      n_errors++;
      print_verdict();
   end

   // main sequence
   initial
   begin
      do_reset(BSR_RST_POWER);
      t_reset();
      t_unimpl();
      t_shared();
      t_pc();
      t_indirect();
      t_core();
      t_warm(BSR_RST_PIN, 1'b0);
      t_warm(BSR_RST_WDOG, 1'b0);
      t_warm(BSR_RST_BROWN, 1'b1);
      print_verdict();
   end
endmodule
